// file: verilog/trace_capture_port.sv
// probe-side capture of the target trace, status and serial pc pins
// How it works
// - target routes user signals onto trace pins
// - target shifts pc serially, 27/31 cycles
// - target drives three status lines every cycle
// - target captures full bus access attributes
// - bus record arrives in at most 8 slices
// - new access preempts unfinished record
// - compressed records carry their own length
// - filtered records are shorter, same framing
// - capture never stalls the target
// - target reset while suspended is flagged
`timescale 1ns/1ns
module trace_capture_port (
    input  wire logic                                    CLK,
    input  wire logic                                    NRST,
    input  wire logic [trace_pkg::DATA_W-1:0]            TRACE_DATA_PINS,
    input  wire logic [trace_pkg::STAT_W-1:0]            TRACE_STATUS_PINS,
    input  wire logic                                    TRACE_AUX_PIN,
    input  wire logic [trace_pkg::DST_W-1:0]             DEBUG_STATUS_LINES,
    input  wire logic                                    DEBUG_PC_SERIAL_OUT,
    input  wire logic                                    TARGET_CORE_CLK,
    input  wire logic                                    TARGET_RESET_N,
    input  wire trace_pkg::mode_t                        MODE,
    input  wire logic                                    PC_LONG,
    input  wire logic                                    BUS_SHORT,
    input  wire logic                                    SUSPENDED,
    input  wire logic [trace_pkg::PC_W-1:0]              RESUME_PC,
    input  wire logic                                    TRIGGER_FIRE,
    input  wire logic [trace_pkg::PC_W-1:0]              TRIGGER_ADDR,
    input  wire logic                                    RESET_COLD,
    output logic                                         SAMPLE_VALID,
    output logic [trace_pkg::LA_W-1:0]                   SAMPLE_DATA,
    output logic [trace_pkg::DST_W-1:0]                  SAMPLE_STATUS,
    output logic [trace_pkg::STAMP_W-1:0]                SAMPLE_STAMP,
    output logic                                         REF_VALID,
    output logic [trace_pkg::PC_W-1:0]                   REF_PC,
    output trace_pkg::ref_src_t                          REF_SRC,
    output logic                                         BUS_VALID,
    output logic [trace_pkg::BUS_REC_W-1:0]              BUS_RECORD,
    output logic [trace_pkg::SLICE_CNT_W-1:0]            BUS_LEN,
    output logic                                         BUS_DROPPED,
    output logic                                         BREAK_ENABLE,
    output logic                                         RESET_FAULT
);
    import trace_pkg::*;

    trace_pins_if pins ();

    assign pins.raw[P_DATA_LO +: DATA_W] = TRACE_DATA_PINS;
    assign pins.raw[P_STAT_LO +: STAT_W] = TRACE_STATUS_PINS;
    assign pins.raw[P_AUX]               = TRACE_AUX_PIN;
    assign pins.raw[P_DST_LO +: DST_W]   = DEBUG_STATUS_LINES;
    assign pins.raw[P_PC]                = DEBUG_PC_SERIAL_OUT;
    assign pins.raw[P_TCLK]              = TARGET_CORE_CLK;
    assign pins.raw[P_TRST]              = TARGET_RESET_N;

    // every pin passes the same filter so all stay cycle-aligned
    pin_sync u_sync (
        .CLK  (CLK),
        .NRST (NRST),
        .pins (pins)
    );

    function automatic logic [SLICE_CNT_W-1:0] rec_len(input logic [STAT_W-1:0] st, input logic short_fmt);
        logic [SLICE_CNT_W-1:0] n;
        n = {1'b0, st[BUS_LEN_W-1:0]} + SLICE_ONE;
        rec_len = short_fmt ? n : BUS_FULL_LEN;
    endfunction

    logic [DATA_W-1:0]      t_data;
    logic [STAT_W-1:0]      t_stat;
    logic                   t_aux;
    logic [DST_W-1:0]       t_dst;
    logic                   t_pc;
    logic                   t_clk;
    logic                   t_rst_n;

    assign t_data  = pins.clean[P_DATA_LO +: DATA_W];
    assign t_stat  = pins.clean[P_STAT_LO +: STAT_W];
    assign t_aux   = pins.clean[P_AUX];
    assign t_dst   = pins.clean[P_DST_LO +: DST_W];
    assign t_pc    = pins.clean[P_PC];
    assign t_clk   = pins.clean[P_TCLK];
    assign t_rst_n = pins.clean[P_TRST];

    logic                   tclk_prev_reg;
    logic                   trst_prev_reg;
    logic                   susp_prev_reg;
    logic                   core_edge;
    logic                   trst_fall;
    logic                   resume_evt;
    logic                   suspend_evt;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tclk_prev_reg <= 1'b0;
            trst_prev_reg <= 1'b0;
            susp_prev_reg <= 1'b0;
        end else begin
            tclk_prev_reg <= t_clk;
            trst_prev_reg <= t_rst_n;
            susp_prev_reg <= SUSPENDED;
        end
    end

    // target core clock must stay well below a quarter of CLK for edges to survive the filter
    assign core_edge   = t_clk & ~tclk_prev_reg;
    assign trst_fall   = trst_prev_reg & ~t_rst_n;
    assign resume_evt  = susp_prev_reg & ~SUSPENDED;
    assign suspend_evt = ~susp_prev_reg & SUSPENDED;

    // free-running core cycle stamp
    logic [STAMP_W-1:0]     stamp_reg;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            stamp_reg <= '0;
        end else if (core_edge) begin
            stamp_reg <= stamp_reg + STAMP_ONE;
        end
    end

    // per-cycle samples: user pins in analyzer mode, status lines in both
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            SAMPLE_VALID  <= 1'b0;
            SAMPLE_DATA   <= '0;
            SAMPLE_STATUS <= '0;
            SAMPLE_STAMP  <= '0;
        end else begin
            SAMPLE_VALID <= core_edge && (MODE == MODE_LA || MODE == MODE_PC);
            if (core_edge) begin
                SAMPLE_DATA   <= (MODE == MODE_LA) ? {t_aux, t_stat, t_data} : '0;
                SAMPLE_STATUS <= t_dst;
                SAMPLE_STAMP  <= stamp_reg;
            end
        end
    end

    // serial pc: a high start cycle, then the pc bits low first
    pc_state_t              pc_state_reg;
    logic [PC_CNT_W-1:0]    pc_cnt_reg;
    logic [PC_W-1:0]        pc_acc_reg;
    logic [PC_CNT_W-1:0]    pc_last;
    logic                   pc_done;

    assign pc_last = (PC_LONG ? PC_LEN_LONG : PC_LEN_SHORT) - PC_DATA_GAP;
    assign pc_done = core_edge && (MODE == MODE_PC) && (pc_state_reg == PC_SHIFT) && (pc_cnt_reg == pc_last);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pc_state_reg <= PC_IDLE;
            pc_cnt_reg   <= '0;
            pc_acc_reg   <= '0;
        end else if (MODE != MODE_PC) begin
            pc_state_reg <= PC_IDLE;
        end else if (core_edge) begin
            unique case (pc_state_reg)
                PC_IDLE: begin
                    if (t_pc) begin
                        pc_state_reg <= PC_SHIFT;
                        pc_cnt_reg   <= '0;
                        pc_acc_reg   <= '0;
                    end
                end
                PC_SHIFT: begin
                    pc_acc_reg[pc_cnt_reg] <= t_pc;
                    pc_cnt_reg             <= pc_cnt_reg + 5'h01;
                    if (pc_cnt_reg == pc_last) begin
                        pc_state_reg <= PC_IDLE;
                    end
                end
            endcase
        end
    end

    logic [PC_W-1:0]        pc_word;

    always_comb begin
        pc_word = pc_acc_reg;
        pc_word[pc_cnt_reg] = t_pc;
    end

    // absolute references; a serial word landing with a resume or trigger is lost
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            REF_VALID <= 1'b0;
            REF_PC    <= '0;
            REF_SRC   <= REF_NONE;
        end else begin
            REF_VALID <= resume_evt | TRIGGER_FIRE | pc_done;
            if (resume_evt) begin
                REF_PC  <= RESUME_PC;
                REF_SRC <= REF_RESUME;
            end else if (TRIGGER_FIRE) begin
                REF_PC  <= TRIGGER_ADDR;
                REF_SRC <= REF_TRIGGER;
            end else if (pc_done) begin
                REF_PC  <= pc_word;
                REF_SRC <= REF_SERIAL;
            end
        end
    end

    // bus trace records: slice 0 carries the start marker
    bus_state_t             bus_state_reg;
    logic [SLICE_CNT_W-1:0] bus_cnt_reg;
    logic [SLICE_CNT_W-1:0] bus_len_reg;
    logic [BUS_MAX_SLICES-1:0][SLICE_W-1:0] bus_acc_reg;
    logic [BUS_MAX_SLICES-1:0][SLICE_W-1:0] bus_acc_next;
    logic [SLICE_W-1:0]     slice;
    logic                   bus_tick;
    logic                   bus_start;
    logic [SLICE_CNT_W-1:0] start_len;
    logic                   bus_done;

    assign slice     = {t_stat[BUS_LEN_W:0], t_data};
    assign bus_tick  = core_edge && (MODE == MODE_BUS);
    assign bus_start = bus_tick && t_stat[BUS_START_BIT];
    assign start_len = rec_len(t_stat, BUS_SHORT);
    assign bus_done  = bus_start ? (start_len == SLICE_ONE)
                                 : (bus_tick && bus_state_reg == BUS_SHIFT && bus_cnt_reg + SLICE_ONE == bus_len_reg);

    always_comb begin
        bus_acc_next = bus_acc_reg;
        if (bus_start) begin
            bus_acc_next    = '0;
            bus_acc_next[0] = slice;
        end else begin
            bus_acc_next[bus_cnt_reg[BUS_LEN_W-1:0]] = slice;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            bus_state_reg <= BUS_IDLE;
            bus_cnt_reg   <= '0;
            bus_len_reg   <= BUS_FULL_LEN;
            bus_acc_reg   <= '0;
        end else if (MODE != MODE_BUS) begin
            bus_state_reg <= BUS_IDLE;
        end else if (bus_start) begin
            // a new access always restarts the record, unfinished or not
            bus_acc_reg   <= bus_acc_next;
            bus_cnt_reg   <= SLICE_ONE;
            bus_len_reg   <= start_len;
            bus_state_reg <= bus_done ? BUS_IDLE : BUS_SHIFT;
        end else if (bus_tick && bus_state_reg == BUS_SHIFT) begin
            bus_acc_reg <= bus_acc_next;
            bus_cnt_reg <= bus_cnt_reg + SLICE_ONE;
            if (bus_done) begin
                bus_state_reg <= BUS_IDLE;
            end
        end
    end

    // outputs are plain pulses with no ready, so nothing upstream can be held off
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            BUS_VALID   <= 1'b0;
            BUS_RECORD  <= '0;
            BUS_LEN     <= '0;
            BUS_DROPPED <= 1'b0;
        end else begin
            BUS_VALID   <= bus_done;
            BUS_DROPPED <= bus_start && bus_state_reg == BUS_SHIFT && MODE == MODE_BUS;
            if (bus_done) begin
                BUS_RECORD <= bus_acc_next;
                BUS_LEN    <= bus_start ? start_len : bus_len_reg;
            end
        end
    end

    // breakpoints stay off after a cold reset taken while running
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            BREAK_ENABLE <= 1'b1;
        end else if (suspend_evt) begin
            BREAK_ENABLE <= 1'b1;
        end else if (trst_fall && RESET_COLD && !SUSPENDED) begin
            BREAK_ENABLE <= 1'b0;
        end
    end

    // a reset during suspension leaves the probe state unreliable; set wins over the resume clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RESET_FAULT <= 1'b0;
        end else if (trst_fall && SUSPENDED) begin
            RESET_FAULT <= 1'b1;
        end else if (resume_evt) begin
            RESET_FAULT <= 1'b0;
        end
    end
endmodule

// file: verilog/trace_pkg.sv
// constants and types shared by the trace capture logic
package trace_pkg;
    localparam int LA_W           = 14;
    localparam int DATA_W         = 8;
    localparam int STAT_W         = 5;
    localparam int DST_W          = 3;
    localparam int PC_W           = 32;
    localparam int STAMP_W        = 32;
    // positions inside the synchronised pin vector
    localparam int P_DATA_LO      = 0;
    localparam int P_STAT_LO      = 8;
    localparam int P_AUX          = 13;
    localparam int P_DST_LO       = 14;
    localparam int P_PC           = 17;
    localparam int P_TCLK         = 18;
    localparam int P_TRST         = 19;
    localparam int PIN_W          = 20;
    // serial pc frame lengths in core cycles, start cycle included
    localparam int PC_CNT_W       = 5;
    localparam logic [PC_CNT_W-1:0] PC_LEN_SHORT = 5'h1b;
    localparam logic [PC_CNT_W-1:0] PC_LEN_LONG  = 5'h1f;
    localparam logic [PC_CNT_W-1:0] PC_DATA_GAP  = 5'h02;
    // bus trace record layout
    localparam int BUS_MAX_SLICES = 8;
    localparam int SLICE_W        = 12;
    localparam int BUS_REC_W      = 96;
    localparam int SLICE_CNT_W    = 4;
    localparam int BUS_START_BIT  = 4;
    localparam int BUS_LEN_W      = 3;
    localparam logic [SLICE_CNT_W-1:0] BUS_FULL_LEN = 4'h8;
    localparam logic [SLICE_CNT_W-1:0] SLICE_ONE    = 4'h1;
    localparam logic [STAMP_W-1:0]     STAMP_ONE    = 32'h0000_0001;

    typedef enum logic [1:0] {
        MODE_LA  = 2'b00,
        MODE_PC  = 2'b01,
        MODE_BUS = 2'b10,
        MODE_OFF = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        REF_RESUME  = 2'b00,
        REF_TRIGGER = 2'b01,
        REF_SERIAL  = 2'b10,
        REF_NONE    = 2'b11
    } ref_src_t;

    typedef enum logic {
        PC_IDLE  = 1'b0,
        PC_SHIFT = 1'b1
    } pc_state_t;

    typedef enum logic {
        BUS_IDLE  = 1'b0,
        BUS_SHIFT = 1'b1
    } bus_state_t;
endpackage

// file: verilog/trace_pins_if.sv
// raw and filtered target pin bundle between the capture core and its synchroniser
`timescale 1ns/1ns
interface trace_pins_if;
    import trace_pkg::*;
    logic [PIN_W-1:0] raw;
    logic [PIN_W-1:0] clean;
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface

// file: verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
    input wire logic      CLK,
    input wire logic      NRST,
    trace_pins_if.sync_side pins
);
    import trace_pkg::*;

    logic [PIN_W-1:0] s1_reg;
    logic [PIN_W-1:0] s2_reg;
    logic [PIN_W-1:0] s3_reg;
    logic [PIN_W-1:0] held_reg;

    genvar i;
    generate
        for (i = 0; i < PIN_W; i++) begin : g_bit
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= pins.raw[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                end
            end

            // a change counts only once two settled stages agree
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    held_reg[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    held_reg[i] <= s3_reg[i];
                end
            end
        end
    endgenerate

    assign pins.clean = held_reg;
endmodule

// file: tb/trace_capture_port_asserts.sv
// concurrent checks on the trace capture port outputs
`timescale 1ns/1ns
module trace_capture_port_asserts (
    input wire logic                          CLK,
    input wire logic                          NRST,
    input wire trace_pkg::mode_t              MODE,
    input wire logic                          BUS_SHORT,
    input wire logic                          SUSPENDED,
    input wire logic [trace_pkg::PC_W-1:0]    RESUME_PC,
    input wire logic                          TRIGGER_FIRE,
    input wire logic [trace_pkg::PC_W-1:0]    TRIGGER_ADDR,
    input wire logic                          RESET_COLD,
    input wire logic                          SAMPLE_VALID,
    input wire logic [trace_pkg::STAMP_W-1:0] SAMPLE_STAMP,
    input wire logic                          REF_VALID,
    input wire logic [trace_pkg::PC_W-1:0]    REF_PC,
    input wire trace_pkg::ref_src_t           REF_SRC,
    input wire logic                          BUS_VALID,
    input wire logic [trace_pkg::SLICE_CNT_W-1:0] BUS_LEN,
    input wire logic                          BREAK_ENABLE,
    input wire logic                          RESET_FAULT
);
    import trace_pkg::*;
    logic [STAMP_W-1:0] last_reg;
    logic               seen_reg;
    // stamp of the previous sample, so ordering can be judged across mode changes
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            last_reg <= '0;
            seen_reg <= 1'b0;
        end else if (SAMPLE_VALID) begin
            last_reg <= SAMPLE_STAMP;
            seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence resume_s;
        $fell(SUSPENDED);
    endsequence
    sequence resume_ref_s;
        REF_VALID && REF_SRC == REF_RESUME && REF_PC == $past(RESUME_PC);
    endsequence
    chk_sample_gap: assert property (SAMPLE_VALID |=> !SAMPLE_VALID [*4])
        else $error("sample pulses too close");
    chk_sample_mode: assert property (SAMPLE_VALID |-> $past(MODE) inside {MODE_LA, MODE_PC})
        else $error("sample outside capture modes");
    chk_stamp_order: assert property (SAMPLE_VALID && seen_reg |-> SAMPLE_STAMP > last_reg)
        else $error("sample stamp not increasing");
    chk_resume_ref: assert property (resume_s |=> resume_ref_s)
        else $error("resume pc not recorded");
    chk_trigger_ref: assert property (TRIGGER_FIRE && !$fell(SUSPENDED) |=>
        REF_VALID && REF_SRC == REF_TRIGGER && REF_PC == $past(TRIGGER_ADDR))
        else $error("trigger address not recorded");
    chk_ref_held: assert property (!REF_VALID |-> $stable(REF_PC) && $stable(REF_SRC))
        else $error("reference changed without pulse");
    chk_break_off: assert property ($fell(BREAK_ENABLE) |-> $past(RESET_COLD) && !$past(SUSPENDED))
        else $error("breaks disabled without cold reset");
    chk_break_hold: assert property (!BREAK_ENABLE && !$rose(SUSPENDED) |=> !BREAK_ENABLE)
        else $error("breaks enabled before suspend");
    chk_break_back: assert property ($rose(SUSPENDED) |=> BREAK_ENABLE)
        else $error("breaks not enabled on suspend");
    chk_fault_sticky: assert property (RESET_FAULT && !$fell(SUSPENDED) |=> RESET_FAULT)
        else $error("reset fault cleared early");
    chk_bus_len: assert property (BUS_VALID |-> BUS_LEN inside {[1:8]} && (BUS_SHORT || BUS_LEN == BUS_FULL_LEN))
        else $error("bus record length out of range");
endmodule

bind trace_capture_port trace_capture_port_asserts trace_capture_port_asserts_i (
    .CLK(CLK), .NRST(NRST), .MODE(MODE), .BUS_SHORT(BUS_SHORT), .SUSPENDED(SUSPENDED),
    .RESUME_PC(RESUME_PC), .TRIGGER_FIRE(TRIGGER_FIRE), .TRIGGER_ADDR(TRIGGER_ADDR),
    .RESET_COLD(RESET_COLD), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_STAMP(SAMPLE_STAMP),
    .REF_VALID(REF_VALID), .REF_PC(REF_PC), .REF_SRC(REF_SRC), .BUS_VALID(BUS_VALID),
    .BUS_LEN(BUS_LEN), .BREAK_ENABLE(BREAK_ENABLE), .RESET_FAULT(RESET_FAULT)
);

// file: tb/target_trace_model.sv
// behavioural target driving trace, status, serial pc and reset pins
`timescale 1ns/1ns
module target_trace_model (
    input  wire logic CLK,
    output logic [7:0] data_pins,
    output logic [4:0] stat_pins,
    output logic       aux_pin,
    output logic [2:0] dst_lines,
    output logic       pc_line,
    output logic       core_clk,
    output logic       reset_n
);
    initial begin
        {data_pins, stat_pins, aux_pin, dst_lines, pc_line, core_clk} = '0;
        reset_n = 1'b1;
    end
    // one core cycle; pins move only while core clock is low, never held back by the probe
    task automatic cycle(input logic [7:0] d, input logic [4:0] s, input logic a, input logic [2:0] st,
                         input logic p);
        @(negedge CLK);
        data_pins = d;
        stat_pins = s;
        aux_pin = a;
        dst_lines = st;
        pc_line = p;
        repeat (8) @(negedge CLK);
        core_clk = 1'b1;
        repeat (8) @(negedge CLK);
        core_clk = 1'b0;
    endtask
    // start cycle then len-1 pc bits, lsb first
    task automatic pc_frame(input int len, input logic [31:0] v);
        cycle(8'h00, 5'h00, 1'b0, 3'h1, 1'b1);
        for (int i = 0; i < len - 1; i++) begin
            cycle(8'h00, 5'h00, 1'b0, 3'h2, v[i]);
        end
    endtask
    // a reset pulse; the bench decides whether the debugger has the core suspended
    task automatic pulse_reset();
        reset_n = 1'b0;
        repeat (16) @(negedge CLK);
        reset_n = 1'b1;
        repeat (16) @(negedge CLK);
    endtask
endmodule

// file: tb/test_trace_capture_port.sv
// self-checking bench for the trace capture port
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module test_trace_capture_port;
    import trace_pkg::*;
    logic clk, nrst, pc_long, bus_short, suspended, trigger_fire, reset_cold;
    logic [7:0] data_pins;
    logic [4:0] stat_pins;
    logic [2:0] dst_lines, sample_status;
    logic aux_pin, pc_line, core_clk, reset_n, sample_valid, ref_valid, bus_valid, bus_dropped;
    logic break_enable, reset_fault;
    logic [31:0] resume_pc, trigger_addr, sample_stamp, ref_pc, ref_pc_c;
    logic [13:0] sample_data;
    logic [95:0] bus_record, rec_c;
    logic [3:0] bus_len, len_c;
    mode_t mode;
    ref_src_t ref_src, ref_src_c;
    logic [13:0] sd_q[$];
    logic [2:0] ss_q[$];
    logic [31:0] st_q[$];
    int n_fail, checks_done, n_ref, n_bus, n_drop;
    target_trace_model target_trace_model_i (.CLK(clk), .data_pins(data_pins), .stat_pins(stat_pins),
        .aux_pin(aux_pin), .dst_lines(dst_lines), .pc_line(pc_line), .core_clk(core_clk), .reset_n(reset_n));
    trace_capture_port trace_capture_port_i (.CLK(clk), .NRST(nrst), .TRACE_DATA_PINS(data_pins),
        .TRACE_STATUS_PINS(stat_pins), .TRACE_AUX_PIN(aux_pin), .DEBUG_STATUS_LINES(dst_lines),
        .DEBUG_PC_SERIAL_OUT(pc_line), .TARGET_CORE_CLK(core_clk), .TARGET_RESET_N(reset_n), .MODE(mode),
        .PC_LONG(pc_long), .BUS_SHORT(bus_short), .SUSPENDED(suspended), .RESUME_PC(resume_pc),
        .TRIGGER_FIRE(trigger_fire), .TRIGGER_ADDR(trigger_addr), .RESET_COLD(reset_cold),
        .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data), .SAMPLE_STATUS(sample_status),
        .SAMPLE_STAMP(sample_stamp), .REF_VALID(ref_valid), .REF_PC(ref_pc), .REF_SRC(ref_src),
        .BUS_VALID(bus_valid), .BUS_RECORD(bus_record), .BUS_LEN(bus_len), .BUS_DROPPED(bus_dropped),
        .BREAK_ENABLE(break_enable), .RESET_FAULT(reset_fault));
    always #2 clk = ~clk;
    // pulses last one cycle, so capture them at every edge
    always @(posedge clk) begin
        if (sample_valid === 1'b1) begin
            sd_q.push_back(sample_data);
            ss_q.push_back(sample_status);
            st_q.push_back(sample_stamp);
        end
        if (ref_valid === 1'b1) begin
            n_ref++;
            ref_pc_c = ref_pc;
            ref_src_c = ref_src;
        end
        if (bus_valid === 1'b1) begin
            n_bus++;
            rec_c = bus_record;
            len_c = bus_len;
        end
        if (bus_dropped === 1'b1) n_drop++;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [13:0] la_val(input int i);
        la_val = 14'h3a5c ^ (14'h0923 * 14'(i));
    endfunction
    task automatic t_la();
        logic [13:0] v;
        mode = MODE_LA;
        for (int i = 0; i < 3; i++) begin
            v = la_val(i);
            target_trace_model_i.cycle(v[7:0], v[12:8], v[13], 3'(i + 5), 1'b0);
        end
        idle(8);
        `CHK("la count", 3, sd_q.size())
        for (int i = 0; i < 3 && i < sd_q.size(); i++) begin
            `CHK("la data", la_val(i), sd_q[i])
            `CHK("la status", 3'(i + 5), ss_q[i])
            `CHK("la stamp", 32'(i), st_q[i])
        end
    endtask
    task automatic t_pc();
        mode = MODE_PC;
        for (int k = 0; k < 2; k++) begin
            pc_long = k[0];
            n_ref = 0;
            sd_q.delete();
            target_trace_model_i.pc_frame(k ? 31 : 27, 32'hfedc_ba98);
            idle(8);
            `CHK("pc ref count", 1, n_ref)
            `CHK("pc ref src", REF_SERIAL, ref_src_c)
            `CHK("pc ref value", k ? 32'h3edc_ba98 : 32'h02dc_ba98, ref_pc_c)
            `CHK("pc mode data", 14'h0000, sd_q[0])
        end
    endtask
    task automatic t_ref();
        mode = MODE_OFF;
        suspended = 1'b1;
        idle(4);
        n_ref = 0;
        resume_pc = 32'h0000_1230;
        trigger_addr = 32'h0000_4560;
        trigger_fire = 1'b1;
        suspended = 1'b0;
        idle(1);
        trigger_fire = 1'b0;
        idle(4);
        `CHK("resume ref count", 1, n_ref)
        `CHK("resume ref src", REF_RESUME, ref_src_c)
        `CHK("resume ref pc", 32'h0000_1230, ref_pc_c)
        trigger_addr = 32'h0000_7890;
        trigger_fire = 1'b1;
        idle(1);
        trigger_fire = 1'b0;
        idle(4);
        `CHK("trigger ref src", REF_TRIGGER, ref_src_c)
        `CHK("trigger ref pc", 32'h0000_7890, ref_pc_c)
    endtask
    // slice 0 carries the start marker and, when short, the length field
    task automatic send_bus(input int n, input int lf, input logic [7:0] base);
        for (int k = 0; k < n; k++) begin
            target_trace_model_i.cycle(base + 8'(k), (k == 0) ? {2'b10, 3'(lf)} : {1'b0, 4'(k)}, 1'b0, 3'h0, 1'b0);
        end
    endtask
    function automatic logic [95:0] exp_rec(input int n, input int lf, input logic [7:0] base);
        exp_rec = '0;
        for (int k = 0; k < n; k++) exp_rec[12*k +: 12] = {(k == 0) ? {1'b0, 3'(lf)} : 4'(k), base + 8'(k)};
    endfunction
    task automatic t_bus();
        mode = MODE_BUS;
        bus_short = 1'b0;
        n_bus = 0;
        n_drop = 0;
        send_bus(3, 0, 8'h10);
        send_bus(8, 0, 8'h40);
        idle(8);
        `CHK("bus dropped", 1, n_drop)
        `CHK("bus count", 1, n_bus)
        `CHK("bus len full", BUS_FULL_LEN, len_c)
        `CHK("bus record full", exp_rec(8, 0, 8'h40), rec_c)
        bus_short = 1'b1;
        for (int j = 0; j < 2; j++) begin
            send_bus(j ? 1 : 3, j ? 0 : 2, 8'h80 + 8'(j));
            idle(8);
            `CHK("bus len short", j ? 4'h1 : 4'h3, len_c)
            `CHK("bus record short", exp_rec(j ? 1 : 3, j ? 0 : 2, 8'h80 + 8'(j)), rec_c)
        end
    endtask
    task automatic t_break();
        mode = MODE_OFF;
        target_trace_model_i.pulse_reset();
        `CHK("break after hot", 1'b1, break_enable)
        reset_cold = 1'b1;
        target_trace_model_i.pulse_reset();
        `CHK("break after cold", 1'b0, break_enable)
        suspended = 1'b1;
        idle(2);
        `CHK("break after suspend", 1'b1, break_enable)
        target_trace_model_i.pulse_reset();
        `CHK("fault set", 1'b1, reset_fault)
        suspended = 1'b0;
        idle(2);
        `CHK("fault cleared", 1'b0, reset_fault)
    endtask
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        mode = MODE_LA;
        {pc_long, bus_short, suspended, trigger_fire, reset_cold} = '0;
        resume_pc = '0;
        trigger_addr = '0;
        idle(8);
        nrst = 1'b1;
        idle(4);
        t_la();
        t_pc();
        t_ref();
        t_bus();
        t_break();
        summarize();
    end
    // the whole run needs roughly 1500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule
